// ==== inc/irq_pkg.sv ====
// constants shared by the interrupt acceptance block and its arbiter
// assumes levels 0..16 travel on five bits and the core mask on four
package irq_pkg;
   localparam int          LEVEL_W       = 5;
   localparam int          MASK_W        = 4;
   localparam logic [4:0]  LEVEL_OFF     = 5'h00;
   localparam logic [4:0]  LEVEL_NMI     = 5'h10;
   localparam logic [4:0]  LEVEL_FIXED   = 5'h0F;
   localparam logic [3:0]  MASK_ON_TOP   = 4'hF;
   localparam int          NUM_FIXED     = 3;
   localparam int          SRC_NMI       = 0;
   localparam int          SRC_BREAK     = 1;
   localparam int          SRC_DEBUG     = 2;
   localparam int          NUM_IRQ_DEF   = 8;
   localparam logic [3:0]  MASK_RESET    = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_OFFER = 3'b010,
      ST_GAP   = 3'b100
   } offer_state_t;
endpackage

// ==== inc/pick_if.sv ====
// carries pending requests and their levels to the arbiter, and the winner back
// assumes N is at least two
`timescale 1ns/10ps
`default_nettype none
interface pick_if #(parameter int N = 11);
   localparam int IDX_W = $clog2(N);
   logic [N-1:0]                      req;
   logic [N-1:0][irq_pkg::LEVEL_W-1:0] level;
   logic                              found;
   logic [IDX_W-1:0]                  win_idx;
   logic [irq_pkg::LEVEL_W-1:0]        win_level;
   modport arbiter (input req, level, output found, win_idx, win_level);
   modport client  (output req, level, input found, win_idx, win_level);
endinterface
`default_nettype wire

// ==== rtl/interrupt_source_priority.sv ====
// interrupt acceptance: latches fixed sources, ranks all requests, offers one to the core
// assumes the core samples the offer on core_clk and answers with a one-cycle core_accept
`timescale 1ns/10ps
`default_nettype none
module interrupt_source_priority #(
   parameter int NUM_IRQ = irq_pkg::NUM_IRQ_DEF
) (
   input  wire logic                                      core_clk,
   input  wire logic                                      rst,
   input  wire logic                                      nmi_pin,
   input  wire logic                                      pin_edge_select,
   input  wire logic                                      break_match,
   input  wire logic                                      debug_irq_instr,
   input  wire logic [NUM_IRQ-1:0]                        irq_req,
   input  wire logic [NUM_IRQ-1:0][irq_pkg::LEVEL_W-1:0]  irq_level_cfg,
   input  wire logic [irq_pkg::MASK_W-1:0]                mask_level_field,
   input  wire logic                                      core_accept,
   output logic                                           exc_request,
   output logic [$clog2(NUM_IRQ+irq_pkg::NUM_FIXED)-1:0]  exc_source,
   output logic [irq_pkg::LEVEL_W-1:0]                    exc_level,
   output logic [irq_pkg::MASK_W-1:0]                     new_mask_level,
   output logic                                           nmi_pending,
   output logic                                           break_pending,
   output logic                                           debug_pending
);
   import irq_pkg::*;
   localparam int N     = NUM_IRQ + NUM_FIXED;
   localparam int IDX_W = $clog2(N);

   pick_if #(.N(N)) pick ();

   priority_pick #(.N(N)) u_pick (
      .p (pick)
   );

   // edge detectors: a primed flag keeps a level present at reset release from firing
   logic primed, next_primed;
   logic nmi_prev, next_nmi_prev;
   logic brk_prev, next_brk_prev;
   logic dbg_prev, next_dbg_prev;
   logic nmi_edge, brk_edge, dbg_edge;

   always_comb begin
      next_primed   = 1'b1;
      next_nmi_prev = nmi_pin;
      next_brk_prev = break_match;
      next_dbg_prev = debug_irq_instr;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         primed   <= 1'b0;
         nmi_prev <= 1'b0;
         brk_prev <= 1'b0;
         dbg_prev <= 1'b0;
      end else begin
         primed   <= next_primed;
         nmi_prev <= next_nmi_prev;
         brk_prev <= next_brk_prev;
         dbg_prev <= next_dbg_prev;
      end
   end

   always_comb begin
      if (pin_edge_select) begin
         nmi_edge = primed && nmi_pin && !nmi_prev;
      end else begin
         nmi_edge = primed && !nmi_pin && nmi_prev;
      end
      brk_edge = primed && break_match && !brk_prev;
      dbg_edge = primed && debug_irq_instr && !dbg_prev;
   end

   // offer handshake
   offer_state_t        state, next_state;
   logic                take;
   logic [IDX_W-1:0]    next_source;
   logic [LEVEL_W-1:0]  next_level;
   logic [MASK_W-1:0]   next_mask;

   assign take = core_accept && (state == ST_OFFER);

   // latched fixed sources: a new edge in the accept cycle wins over the clear
   logic next_nmi_pend, next_brk_pend, next_dbg_pend;

   always_comb begin
      next_nmi_pend = nmi_pending;
      next_brk_pend = break_pending;
      next_dbg_pend = debug_pending;
      if (take && exc_source == IDX_W'(SRC_NMI)) begin
         next_nmi_pend = 1'b0;
      end
      if (take && exc_source == IDX_W'(SRC_BREAK)) begin
         next_brk_pend = 1'b0;
      end
      if (take && exc_source == IDX_W'(SRC_DEBUG)) begin
         next_dbg_pend = 1'b0;
      end
      if (nmi_edge) begin
         next_nmi_pend = 1'b1;
      end
      if (brk_edge) begin
         next_brk_pend = 1'b1;
      end
      if (dbg_edge) begin
         next_dbg_pend = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         nmi_pending   <= 1'b0;
         break_pending <= 1'b0;
         debug_pending <= 1'b0;
      end else begin
         nmi_pending   <= next_nmi_pend;
         break_pending <= next_brk_pend;
         debug_pending <= next_dbg_pend;
      end
   end

   // per-source eligibility against the current mask
   logic [N-1:0]              src_pend;
   logic [N-1:0][LEVEL_W-1:0] src_level;

   assign src_pend[SRC_NMI]    = nmi_pending;
   assign src_pend[SRC_BREAK]  = break_pending;
   assign src_pend[SRC_DEBUG]  = debug_pending;
   assign src_level[SRC_NMI]   = LEVEL_NMI;
   assign src_level[SRC_BREAK] = LEVEL_FIXED;
   assign src_level[SRC_DEBUG] = LEVEL_FIXED;

   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g++) begin : g_irq
         assign src_pend[NUM_FIXED+g]  = irq_req[g];
         assign src_level[NUM_FIXED+g] = irq_level_cfg[g];
      end
      for (g = 0; g < N; g++) begin : g_elig
         // level 16 passes any mask; level 0 never passes
         assign pick.req[g] = src_pend[g] && (src_level[g] != LEVEL_OFF) &&
                              ((src_level[g] >= LEVEL_NMI) ||
                               (src_level[g] > {1'b0, mask_level_field}));
      end
   endgenerate
   assign pick.level = src_level;

   always_comb begin
      next_state  = state;
      next_source = exc_source;
      next_level  = exc_level;
      next_mask   = new_mask_level;
      case (state)
         ST_IDLE, ST_OFFER: begin
            if (take) begin
               // two quiet cycles, ST_GAP then ST_IDLE, let the cleared pending bit settle before a new offer
               next_state = ST_GAP;
            end else if (pick.found) begin
               next_state  = ST_OFFER;
               next_source = pick.win_idx;
               next_level  = pick.win_level;
               if (pick.win_level >= LEVEL_NMI) begin
                  next_mask = MASK_ON_TOP;
               end else begin
                  next_mask = pick.win_level[MASK_W-1:0];
               end
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_GAP: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state          <= ST_IDLE;
         exc_source     <= '0;
         exc_level      <= LEVEL_OFF;
         new_mask_level <= MASK_RESET;
      end else begin
         state          <= next_state;
         exc_source     <= next_source;
         exc_level      <= next_level;
         new_mask_level <= next_mask;
      end
   end

   assign exc_request = (state == ST_OFFER);

   // checks
   AST_LEVEL_RANGE: assert property (@(posedge core_clk) disable iff (rst)
      exc_request |-> exc_level <= LEVEL_NMI)
      else $error("offered level above 16");

   AST_ZERO_NEVER: assert property (@(posedge core_clk) disable iff (rst)
      exc_request |-> exc_level != LEVEL_OFF)
      else $error("level zero offered");

   AST_NMI_ALWAYS: assert property (@(posedge core_clk) disable iff (rst)
      (nmi_pending && state == ST_IDLE) |=> (exc_request && exc_source == IDX_W'(SRC_NMI) &&
                                            exc_level == LEVEL_NMI))
      else $error("pending pin interrupt not offered next cycle");

   AST_NMI_EDGE: assert property (@(posedge core_clk) disable iff (rst)
      ($past(primed) && primed && (pin_edge_select ? $rose(nmi_pin) : $fell(nmi_pin)))
      |=> nmi_pending)
      else $error("selected pin edge not latched");

   AST_NMI_MASK: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_source == IDX_W'(SRC_NMI)) |-> new_mask_level == MASK_ON_TOP)
      else $error("pin interrupt mask not 15");

   AST_BREAK_OFFER: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_source == IDX_W'(SRC_BREAK)) |->
      (exc_level == LEVEL_FIXED && new_mask_level == MASK_ON_TOP))
      else $error("break offer level or mask wrong");

   AST_DEBUG_OFFER: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_source == IDX_W'(SRC_DEBUG)) |->
      (exc_level == LEVEL_FIXED && new_mask_level == MASK_ON_TOP))
      else $error("debug offer level or mask wrong");

   AST_DEBUG_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      (debug_pending && !(take && exc_source == IDX_W'(SRC_DEBUG))) |=> debug_pending)
      else $error("debug request lost before acceptance");

   AST_ABOVE_MASK: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_level != LEVEL_NMI) |-> exc_level > {1'b0, $past(mask_level_field)})
      else $error("offer not above mask");

   AST_GAP_AFTER_TAKE: assert property (@(posedge core_clk) disable iff (rst)
      take |=> !exc_request ##1 (state == ST_IDLE))
      else $error("no quiet cycle after acceptance");

   // latched flags: clear on acceptance unless a fresh edge lands in the same cycle
   AST_NMI_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      (take && exc_source == IDX_W'(SRC_NMI) && !nmi_edge)
      |=> !nmi_pending)
      else $error("pin interrupt still pending after acceptance");

   AST_BREAK_EDGE: assert property (@(posedge core_clk) disable iff (rst)
      ($past(primed) && primed && $rose(break_match))
      |=> break_pending)
      else $error("break match edge not latched");

   AST_BREAK_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      (take && exc_source == IDX_W'(SRC_BREAK) && !brk_edge)
      |=> !break_pending)
      else $error("break request still pending after acceptance");

   AST_DEBUG_EDGE: assert property (@(posedge core_clk) disable iff (rst)
      ($past(primed) && primed && $rose(debug_irq_instr))
      |=> debug_pending)
      else $error("debug instruction edge not latched");

   AST_DEBUG_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      (take && exc_source == IDX_W'(SRC_DEBUG) && !dbg_edge)
      |=> !debug_pending)
      else $error("debug request still pending after acceptance");

   // a level already standing when reset lets go must not look like an edge
   AST_UNPRIMED_QUIET: assert property (@(posedge core_clk) disable iff (rst)
      !primed
      |=> !(nmi_pending || break_pending || debug_pending))
      else $error("edge latched before detectors were armed");

   AST_MASK_FOLLOWS: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_level < LEVEL_NMI)
      |-> new_mask_level == exc_level[MASK_W-1:0])
      else $error("mask to load differs from offered level");

   // the offer was ranked one cycle earlier, so rank order is judged against that cycle
   AST_NMI_FIRST: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_source != IDX_W'(SRC_NMI))
      |-> !$past(nmi_pending))
      else $error("lower source offered while pin interrupt pending");

   AST_FIXED_FIRST: assert property (@(posedge core_clk) disable iff (rst)
      (exc_request && exc_level < LEVEL_FIXED)
      |-> (!$past(break_pending) && !$past(debug_pending)))
      else $error("lower level offered while a level 15 source pending");

   COV_NMI_TAKEN: cover property (@(posedge core_clk) disable iff (rst)
      take && exc_source == IDX_W'(SRC_NMI));
   COV_BREAK_TAKEN: cover property (@(posedge core_clk) disable iff (rst)
      take && exc_source == IDX_W'(SRC_BREAK));
   COV_DEBUG_TAKEN: cover property (@(posedge core_clk) disable iff (rst)
      take && exc_source == IDX_W'(SRC_DEBUG));
   COV_IRQ_TAKEN: cover property (@(posedge core_clk) disable iff (rst)
      take && exc_source >= IDX_W'(NUM_FIXED));
   COV_REOFFER: cover property (@(posedge core_clk) disable iff (rst)
      take ##3 exc_request);
endmodule // interrupt_source_priority
`default_nettype wire

// ==== rtl/priority_pick.sv ====
// combinational arbiter: highest level among eligible requests
// assumes the client only raises req for requests that may be taken
`timescale 1ns/10ps
`default_nettype none
module priority_pick #(
   parameter int N = 11
) (
   pick_if.arbiter p
);
   import irq_pkg::*;
   localparam int IDX_W = $clog2(N);

   logic               best_found;
   logic [IDX_W-1:0]   best_idx;
   logic [LEVEL_W-1:0] best_level;

   // scan downward so that on a tie the lowest index wins
   always_comb begin
      best_found = 1'b0;
      best_idx   = '0;
      best_level = LEVEL_OFF;
      for (int i = N - 1; i >= 0; i--) begin
         if (p.req[i] && (!best_found || p.level[i] >= best_level)) begin
            best_found = 1'b1;
            best_idx   = IDX_W'(i);
            best_level = p.level[i];
         end
      end
   end

   assign p.found     = best_found;
   assign p.win_idx   = best_idx;
   assign p.win_level = best_level;
endmodule // priority_pick
`default_nettype wire

// ==== verification/core_model.sv ====
// processor core stand-in: takes each offer after a set wait, then loads the mask
// does not assume the offer holds steady until core_accept; the block re-ranks it, and may withdraw it, on every cycle it stands
`timescale 1ns/10ps
`default_nettype none
module core_model (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       exc_request,
   input  wire logic [3:0] new_mask_level,
   input  wire logic [3:0] wait_cycles,
   input  wire logic       set_mask,
   input  wire logic [3:0] mask_value,
   output logic            core_accept,
   output logic [3:0]      mask_level_field
);
   logic [3:0] waited;
   // a slow core leaves pending flags visible before acceptance
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_accept      <= 1'b0;
         waited           <= 4'h0;
         mask_level_field <= 4'h0;
      end else begin
         core_accept <= exc_request && !core_accept && waited >= wait_cycles;
         waited      <= (exc_request && !core_accept && waited != 4'hF) ? waited + 4'h1 : 4'h0;
         if (core_accept && exc_request)
            mask_level_field <= new_mask_level;
         else if (set_mask)
            mask_level_field <= mask_value;
      end
   end
endmodule // core_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the interrupt acceptance block
// assumes core_model stands in for the processor core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import irq_pkg::*;
   logic            core_clk, rst, nmi_pin, pin_edge_select, break_match, debug_irq_instr;
   logic            core_accept, exc_request, nmi_pending, break_pending, debug_pending, set_mask;
   logic [7:0]      irq_req;
   logic [7:0][4:0] irq_level_cfg;
   logic [3:0]      mask_level_field, new_mask_level, wait_cycles, mask_value, exc_source;
   logic [4:0]      exc_level;
   int              errors, tests_run, cycles;

   interrupt_source_priority #(.NUM_IRQ(8)) dut (.core_clk(core_clk), .rst(rst), .nmi_pin(nmi_pin),
      .pin_edge_select(pin_edge_select), .break_match(break_match), .debug_irq_instr(debug_irq_instr),
      .irq_req(irq_req), .irq_level_cfg(irq_level_cfg), .mask_level_field(mask_level_field),
      .core_accept(core_accept), .exc_request(exc_request), .exc_source(exc_source), .exc_level(exc_level),
      .new_mask_level(new_mask_level), .nmi_pending(nmi_pending), .break_pending(break_pending),
      .debug_pending(debug_pending));
   core_model core (.core_clk(core_clk), .rst(rst), .exc_request(exc_request),
      .new_mask_level(new_mask_level), .wait_cycles(wait_cycles), .set_mask(set_mask),
      .mask_value(mask_value), .core_accept(core_accept), .mask_level_field(mask_level_field));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // waits for the accept edge, then checks what the core took there
   task automatic take(input logic [7:0] s, input logic [4:0] l, input logic [3:0] m);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!(core_accept === 1'b1 && exc_request === 1'b1) && n < 40);
      chk(n < 40, 1);
      chk(exc_source, s);
      chk(exc_level, l);
      chk(new_mask_level, m);
   endtask

   task automatic quiet(input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         if (exc_request !== 1'b0)
            bad = 1'b1;
      end
      chk(bad, 0);
   endtask

   task automatic set_m(input logic [3:0] v);
      @(posedge core_clk);
      set_mask   <= 1'b1;
      mask_value <= v;
      @(posedge core_clk);
      set_mask   <= 1'b0;
   endtask

   task automatic t_nmi();
      set_m(4'hF);
      @(posedge core_clk);
      nmi_pin <= 1'b1;
      take(0, 5'h10, 4'hF);
      quiet(6);
      chk(nmi_pending, 8'h00);
      pin_edge_select <= 1'b0;
      @(posedge core_clk);
      nmi_pin <= 1'b0;
      take(0, 5'h10, 4'hF);
      $display("test pin interrupt done");
   endtask

   task automatic t_fixed();
      set_m(4'h0);
      break_match <= 1'b1;
      @(posedge core_clk);
      break_match <= 1'b0;
      take(1, 5'h0F, 4'hF);
      set_m(4'h0);
      chk(break_pending, 8'h00);
      wait_cycles     <= 4'hF;
      debug_irq_instr <= 1'b1;
      @(posedge core_clk);
      debug_irq_instr <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk(debug_pending, 1);
      take(2, 5'h0F, 4'hF);
      wait_cycles <= 4'h0;
      @(posedge core_clk);
      chk(debug_pending, 0);
      $display("test fixed sources done");
   endtask

   task automatic t_mask();
      set_m(4'h0);
      irq_level_cfg[0] <= 5'h00;
      irq_req[0]       <= 1'b1;
      quiet(8);
      irq_req[0]       <= 1'b0;
      set_m(4'h5);
      irq_level_cfg[1] <= 5'h05;
      irq_req[1]       <= 1'b1;
      quiet(8);
      set_m(4'h4);
      take(4, 5'h05, 4'h5);
      irq_req[1] <= 1'b0;
      set_m(4'h0);
      irq_level_cfg[2] <= 5'h03;
      irq_level_cfg[3] <= 5'h09;
      irq_req          <= 8'h0C;
      take(6, 5'h09, 4'h9);
      irq_req <= 8'h04;
      set_m(4'h0);
      take(5, 5'h03, 4'h3);
      irq_req <= 8'h00;
      set_m(4'hF);
      irq_level_cfg[4] <= 5'h10;
      irq_req[4]       <= 1'b1;
      take(7, 5'h10, 4'hF);
      irq_req <= 8'h00;
      $display("test maskable requests done");
   endtask

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      rst             = 1'b1;
      nmi_pin         = 1'b0;
      pin_edge_select = 1'b1;
      break_match     = 1'b0;
      debug_irq_instr = 1'b0;
      irq_req         = 8'h00;
      irq_level_cfg   = '0;
      wait_cycles     = 4'h0;
      set_mask        = 1'b0;
      mask_value      = 4'h0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_nmi();
      t_fixed();
      t_mask();
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
